// File: hdl/tcsi_timer.sv
// Timer control, status and interrupt logic of a 16-bit free-running timer.
// Assumes an AXI4-Lite master on i_clock; pins are asynchronous and synchronised here.
`timescale 1ns/1ns
module tcsi_timer import tcsi_pkg::*; #(
	parameter bit HAS_EXT_CLK = 1'b1
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire tcsi_pins_t i_pins,
	input wire logic i_irq_mask,
	input wire logic i_wait_state,
	output logic o_irq,
	output logic o_wake,
	output logic o_cmp1_out_pin,
	output logic o_cmp1_out_oe,
	output logic o_cmp2_out_pin,
	output logic o_cmp2_out_oe
);
	tcsi_ctrl_a_t ctrl_a;
	tcsi_ctrl_b_t ctrl_b;
	logic timer_freeze;
	logic [4:0] flags;
	logic [4:0] armed;
	logic [15:0] counter, cmp1_value, cmp2_value, cap1_value, cap2_value;
	logic [15:0] cmp1_act, cmp2_act;
	logic [7:0] cmp1_hi_buf, cmp2_hi_buf;
	logic cmp1_inhibit, cmp2_inhibit;
	logic [2:0] presc;
	logic level1, level2;
	logic pulse_run;
	tcsi_pins_t sync1, sync2, sync3;

	// Pin synchronisers; sync3 is the previous sampled level
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= i_pins;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	function automatic logic edge_hit(input logic now, input logic prev, input logic rise);
		edge_hit = rise ? (now & ~prev) : (~now & prev);
	endfunction

	logic cap1_edge, cap2_edge, ext_edge;
	assign cap1_edge = edge_hit(sync2.cap1, sync3.cap1, ctrl_a.cap1_edge_sel);
	assign cap2_edge = edge_hit(sync2.cap2, sync3.cap2, ctrl_b.cap2_edge_sel);
	assign ext_edge = edge_hit(sync2.ext_clk, sync3.ext_clk, ctrl_b.ext_clk_edge);

	logic pwm_mode, opm_mode;
	assign pwm_mode = ctrl_b.pulse_width_sel;
	assign opm_mode = ctrl_b.single_pulse_sel & ~ctrl_b.pulse_width_sel;

	// Bus handshake: write address and data accepted together
	logic wr_go, rd_go;
	logic [7:0] wa, ra;
	assign o_awready = i_awvalid & i_wvalid & ~o_bvalid;
	assign o_wready = o_awready;
	assign wr_go = o_awready;
	assign o_arready = ~o_rvalid;
	assign rd_go = i_arvalid & o_arready;
	assign wa = i_awaddr & 8'hFC;
	assign ra = i_araddr & 8'hFC;
	logic wr_en;
	assign wr_en = wr_go & i_wstrb[0];

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a >= TCSI_OFS_CTRL_B) && (a <= TCSI_OFS_CMP2_LO);
	endfunction

	// Low-byte access (read or write) clears the armed flag, except at TCSI_OFS_ACNT_LO
	function automatic logic touched(input logic [7:0] ofs, input logic r, input logic w,
		input logic [7:0] rad, input logic [7:0] wad);
		touched = (r && rad == ofs) || (w && wad == ofs);
	endfunction

	// Timer tick
	logic tick;
	always_comb begin
		tick = 1'b0;
		case (tcsi_clk_t'(ctrl_b.clk_sel))
			TCSI_CLK_DIV4: tick = presc[1:0] == TCSI_DIV4[1:0];
			TCSI_CLK_DIV2: tick = presc[0] == TCSI_DIV2[0];
			TCSI_CLK_DIV8: tick = presc == TCSI_DIV8;
			TCSI_CLK_EXT: tick = HAS_EXT_CLK & ext_edge;
			default: tick = 1'b0;
		endcase
		if (timer_freeze)
			tick = 1'b0;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			presc <= '0;
		else if (!timer_freeze)
			presc <= presc + 3'h1;
	end

	logic match1, match2;
	assign match1 = tick && counter == cmp1_act && !cmp1_inhibit;
	assign match2 = tick && counter == cmp2_act && !cmp2_inhibit;
	logic opm_start;
	assign opm_start = opm_mode & cap1_edge;

	// Counter
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			counter <= TCSI_CNT_RST;
		else if (wr_en && (wa == TCSI_OFS_CNT_LO || wa == TCSI_OFS_ACNT_LO))
			counter <= TCSI_CNT_RST;
		else if (opm_start && !timer_freeze)
			counter <= TCSI_CNT_RST;
		else if (pwm_mode && match2)
			counter <= TCSI_CNT_RST;
		else if (tick)
			counter <= counter + 16'h0001;
	end

	// Compare registers; high write inhibits until low written; PWM loads at period end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmp1_value <= TCSI_CMP_RST;
			cmp2_value <= TCSI_CMP_RST;
			cmp1_hi_buf <= TCSI_CMP_RST[15:8];
			cmp2_hi_buf <= TCSI_CMP_RST[15:8];
			cmp1_inhibit <= 1'b0;
			cmp2_inhibit <= 1'b0;
		end else if (wr_en) begin
			case (wa)
				TCSI_OFS_CMP1_HI: begin
					cmp1_hi_buf <= i_wdata[7:0];
					cmp1_inhibit <= 1'b1;
				end
				TCSI_OFS_CMP1_LO: begin
					cmp1_value <= {cmp1_hi_buf, i_wdata[7:0]};
					cmp1_inhibit <= 1'b0;
				end
				TCSI_OFS_CMP2_HI: begin
					cmp2_hi_buf <= i_wdata[7:0];
					cmp2_inhibit <= 1'b1;
				end
				TCSI_OFS_CMP2_LO: begin
					cmp2_value <= {cmp2_hi_buf, i_wdata[7:0]};
					cmp2_inhibit <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmp1_act <= TCSI_CMP_RST;
			cmp2_act <= TCSI_CMP_RST;
		end else if (!pwm_mode || match2 || counter == TCSI_CNT_RST) begin
			cmp1_act <= cmp1_value;
			cmp2_act <= cmp2_value;
		end
	end

	// Captures; cap1 not a capture in pulse modes
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cap1_value <= '0;
			cap2_value <= '0;
		end else begin
			if (cap1_edge && !pwm_mode)
				cap1_value <= opm_mode ? 16'hFFFD : counter;
			if (cap2_edge)
				cap2_value <= counter;
		end
	end

	// Output levels
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			level1 <= 1'b0;
			level2 <= 1'b0;
			pulse_run <= 1'b0;
		end else if (pwm_mode) begin
			if (match2)
				level1 <= ctrl_a.out_level2;
			else if (match1)
				level1 <= ctrl_a.out_level1;
		end else if (opm_mode) begin
			if (opm_start && !timer_freeze) begin
				level1 <= ctrl_a.out_level2;
				pulse_run <= 1'b1;
			end else if (match1 && pulse_run) begin
				level1 <= ctrl_a.out_level1;
				pulse_run <= 1'b0;
			end
		end else begin
			pulse_run <= 1'b0;
			if (ctrl_a.force_level1)
				level1 <= ctrl_a.out_level1;
			else if (match1)
				level1 <= ctrl_a.out_level1;
			if (ctrl_a.force_level2)
				level2 <= ctrl_a.out_level2;
			else if (match2)
				level2 <= ctrl_a.out_level2;
		end
	end

	assign o_cmp1_out_pin = level1;
	assign o_cmp2_out_pin = level2;
	assign o_cmp1_out_oe = ctrl_b.cmp1_pin_en & ~timer_freeze;
	assign o_cmp2_out_oe = ctrl_b.cmp2_pin_en & ~timer_freeze & ~pwm_mode & ~opm_mode;

	// Flag events, order cap1 cmp1 ovf cap2 cmp2
	logic [4:0] set_ev, clr_ev;
	assign set_ev[4] = (cap1_edge && !pwm_mode) || (pwm_mode && match2);
	assign set_ev[3] = match1 && !pwm_mode && !opm_mode;
	assign set_ev[2] = tick && counter == 16'hFFFF;
	assign set_ev[1] = cap2_edge;
	assign set_ev[0] = match2 && !pwm_mode;
	assign clr_ev[4] = touched(TCSI_OFS_CAP1_LO, rd_go, wr_go, ra, wa);
	assign clr_ev[3] = touched(TCSI_OFS_CMP1_LO, rd_go, wr_go, ra, wa);
	assign clr_ev[2] = touched(TCSI_OFS_CNT_LO, rd_go, wr_go, ra, wa);
	assign clr_ev[1] = touched(TCSI_OFS_CAP2_LO, rd_go, wr_go, ra, wa);
	assign clr_ev[0] = touched(TCSI_OFS_CMP2_LO, rd_go, wr_go, ra, wa);

	logic status_rd;
	assign status_rd = rd_go && ra == TCSI_OFS_STATUS;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flags <= '0;
			armed <= '0;
		end else begin
			flags <= set_ev | (flags & ~(clr_ev & armed)); // set wins
			if (status_rd)
				armed <= flags;
			else
				armed <= armed & ~clr_ev & flags;
		end
	end

	// Control registers
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_a <= TCSI_CTRL_RST;
			ctrl_b <= TCSI_CTRL_RST;
			timer_freeze <= 1'b0;
		end else if (wr_en) begin
			if (wa == TCSI_OFS_CTRL_A)
				ctrl_a <= i_wdata[7:0];
			if (wa == TCSI_OFS_CTRL_B)
				ctrl_b <= i_wdata[7:0];
			if (wa == TCSI_OFS_STATUS)
				timer_freeze <= i_wdata[TCSI_F_FREEZE];
		end
	end

	// Interrupt request and wake
	logic irq_raw;
	assign irq_raw = (ctrl_a.capture_irq_en & (flags[4] | flags[1]))
		| (ctrl_a.compare_irq_en & (flags[3] | flags[0]))
		| (ctrl_a.overflow_irq_en & flags[2]);
	assign o_irq = irq_raw & ~i_irq_mask;
	assign o_wake = irq_raw & i_wait_state;

	// Read data
	logic [7:0] rd_byte;
	always_comb begin
		case (ra)
			TCSI_OFS_CTRL_A: rd_byte = ctrl_a;
			TCSI_OFS_CTRL_B: rd_byte = ctrl_b;
			TCSI_OFS_STATUS: rd_byte = {flags, timer_freeze, 2'b00};
			TCSI_OFS_CAP1_HI: rd_byte = cap1_value[15:8];
			TCSI_OFS_CAP1_LO: rd_byte = cap1_value[7:0];
			TCSI_OFS_CMP1_HI: rd_byte = cmp1_value[15:8];
			TCSI_OFS_CMP1_LO: rd_byte = cmp1_value[7:0];
			TCSI_OFS_CNT_HI: rd_byte = counter[15:8];
			TCSI_OFS_CNT_LO: rd_byte = counter[7:0];
			TCSI_OFS_ACNT_HI: rd_byte = counter[15:8];
			TCSI_OFS_ACNT_LO: rd_byte = counter[7:0];
			TCSI_OFS_CAP2_HI: rd_byte = cap2_value[15:8];
			TCSI_OFS_CAP2_LO: rd_byte = cap2_value[7:0];
			TCSI_OFS_CMP2_HI: rd_byte = cmp2_value[15:8];
			TCSI_OFS_CMP2_LO: rd_byte = cmp2_value[7:0];
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= TCSI_RESP_OKAY;
		end else if (rd_go) begin
			o_rvalid <= 1'b1;
			o_rdata <= {24'h000000, rd_byte};
			o_rresp <= mapped(ra) ? TCSI_RESP_OKAY : TCSI_RESP_SLVERR;
		end else if (i_rready)
			o_rvalid <= 1'b0;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bvalid <= 1'b0;
			o_bresp <= TCSI_RESP_OKAY;
		end else if (wr_go) begin
			o_bvalid <= 1'b1;
			o_bresp <= mapped(wa) ? TCSI_RESP_OKAY : TCSI_RESP_SLVERR;
		end else if (i_bready)
			o_bvalid <= 1'b0;
	end

	// Checks
	irq_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_irq |-> !i_irq_mask && irq_raw) else $error("irq with mask set");
	cap_irq_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(ctrl_a.capture_irq_en && flags[1] && !i_irq_mask) |-> o_irq) else $error("cap irq missing");
	cmp_irq_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(!ctrl_a.compare_irq_en && !ctrl_a.capture_irq_en && !ctrl_a.overflow_irq_en) |-> !o_irq)
		else $error("irq while disabled");
	ovf_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		set_ev[2] |=> flags[2] && counter == 16'h0000) else $error("overflow flag missed");
	freeze_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(timer_freeze && !wr_go && !opm_start) |=> $stable(counter)) else $error("counter moved frozen");
	cnt_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(wr_en && wa == TCSI_OFS_CNT_LO) |=> counter == 16'hFFFC) else $error("counter reset failed");
	clr_arm_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(clr_ev[2] && !armed[2] && flags[2]) |=> flags[2]) else $error("unarmed flag cleared");
	pwm_reload_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(pwm_mode && match2 && !wr_en) |=> counter == 16'hFFFC && flags[4]) else $error("pwm reload");
	div4_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(ctrl_b.clk_sel == 2'b00 && tick) |=> !(tick && ctrl_b.clk_sel == 2'b00) [*3])
		else $error("div4 tick spacing");
	force1_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(ctrl_a.force_level1 && !pwm_mode && !ctrl_b.single_pulse_sel) |=> level1 == $past(ctrl_a.out_level1))
		else $error("force level1");
endmodule

// File: hdl/tcsi_pkg.sv
// Package for the timer control, status and interrupt block.
// Assumes a 32-bit AXI4-Lite register bus, one 8-bit register per word.
package tcsi_pkg;
	// Byte addresses on the AXI4-Lite bus
	localparam logic [7:0] TCSI_OFS_CTRL_B = 8'h04;
	localparam logic [7:0] TCSI_OFS_CTRL_A = 8'h08;
	localparam logic [7:0] TCSI_OFS_STATUS = 8'h0C;
	localparam logic [7:0] TCSI_OFS_CAP1_HI = 8'h10;
	localparam logic [7:0] TCSI_OFS_CAP1_LO = 8'h14;
	localparam logic [7:0] TCSI_OFS_CMP1_HI = 8'h18;
	localparam logic [7:0] TCSI_OFS_CMP1_LO = 8'h1C;
	localparam logic [7:0] TCSI_OFS_CNT_HI = 8'h20;
	localparam logic [7:0] TCSI_OFS_CNT_LO = 8'h24;
	localparam logic [7:0] TCSI_OFS_ACNT_HI = 8'h28;
	localparam logic [7:0] TCSI_OFS_ACNT_LO = 8'h2C;
	localparam logic [7:0] TCSI_OFS_CAP2_HI = 8'h30;
	localparam logic [7:0] TCSI_OFS_CAP2_LO = 8'h34;
	localparam logic [7:0] TCSI_OFS_CMP2_HI = 8'h38;
	localparam logic [7:0] TCSI_OFS_CMP2_LO = 8'h3C;
	// Reset values
	localparam logic [7:0] TCSI_CTRL_RST = 8'h00;
	localparam logic [15:0] TCSI_CNT_RST = 16'hFFFC;
	localparam logic [15:0] TCSI_CMP_RST = 16'h8000;
	// Prescaler divide counts
	localparam logic [2:0] TCSI_DIV2 = 3'h1;
	localparam logic [2:0] TCSI_DIV4 = 3'h3;
	localparam logic [2:0] TCSI_DIV8 = 3'h7;
	// Status bit positions
	localparam int TCSI_F_CAP1 = 7;
	localparam int TCSI_F_CMP1 = 6;
	localparam int TCSI_F_OVF = 5;
	localparam int TCSI_F_CAP2 = 4;
	localparam int TCSI_F_CMP2 = 3;
	localparam int TCSI_F_FREEZE = 2;
	localparam logic [1:0] TCSI_RESP_OKAY = 2'h0;
	localparam logic [1:0] TCSI_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic capture_irq_en;
		logic compare_irq_en;
		logic overflow_irq_en;
		logic force_level2;
		logic force_level1;
		logic out_level2;
		logic cap1_edge_sel;
		logic out_level1;
	} tcsi_ctrl_a_t;

	typedef struct packed {
		logic cmp1_pin_en;
		logic cmp2_pin_en;
		logic single_pulse_sel;
		logic pulse_width_sel;
		logic [1:0] clk_sel;
		logic cap2_edge_sel;
		logic ext_clk_edge;
	} tcsi_ctrl_b_t;

	typedef struct packed {
		logic cap1;
		logic cap2;
		logic ext_clk;
	} tcsi_pins_t;

	typedef enum logic [1:0] {TCSI_CLK_DIV4, TCSI_CLK_DIV2, TCSI_CLK_DIV8, TCSI_CLK_EXT} tcsi_clk_t;
endpackage

// File: dv/tcsi_pin_model.sv
// Board-side sources: the two capture pins and the external clock pin.
// Assumes the bench calls its tasks; levels move just after a clock edge.
`timescale 1ns/1ns
module tcsi_pin_model import tcsi_pkg::*; (
	input wire logic i_clock,
	output tcsi_pins_t o_pins
);
	initial o_pins = '0;
	// Move one capture pin, then let the synchroniser settle
	task automatic set_cap(input int p, input logic lvl);
		@(posedge i_clock);
		if (p == 0) o_pins.cap1 <= lvl;
		else o_pins.cap2 <= lvl;
		repeat (6) @(posedge i_clock);
	endtask
	// External clock stands still between the edges asked for
	task automatic set_ext(input logic lvl);
		@(posedge i_clock);
		o_pins.ext_clk <= lvl;
		repeat (6) @(posedge i_clock);
	endtask
endmodule

// File: dv/tcsi_timer_tb_top.sv
// Self-checking bench for the timer control, status and interrupt block.
// Assumes the pin model on the capture and clock pins; 100 MHz clock.
`timescale 1ns/1ns
module tcsi_timer_tb_top import tcsi_pkg::*; ;
	logic i_clock = 1'h0, i_rst_n = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic irq_mask = 1'h0, wait_st = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, irq, wake, p1, oe1, p2, oe2;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rv, e;
	tcsi_pins_t pins;
	int bad_count = 0, n_compared = 0, m, d;

	tcsi_pin_model tcsi_pin_model_i (.i_clock(i_clock), .o_pins(pins));
	tcsi_timer tcsi_timer_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_pins(pins), .i_irq_mask(irq_mask), .i_wait_state(wait_st),
		.o_irq(irq), .o_wake(wake), .o_cmp1_out_pin(p1), .o_cmp1_out_oe(oe1),
		.o_cmp2_out_pin(p2), .o_cmp2_out_oe(oe2));

	always #5 i_clock = ~i_clock;

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clock);
		awaddr <= a;
		wdata <= {24'h000000, v};
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do @(posedge i_clock); while (!(awready === 1'h1 && wready === 1'h1));
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		do @(posedge i_clock); while (bvalid !== 1'h1);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clock);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge i_clock); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge i_clock); while (rvalid !== 1'h1);
		rv = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask
	task automatic stf(input int b, input logic x);
		rd(TCSI_OFS_STATUS);
		chk("status flag", 32'(x), 32'(rv[b]));
	endtask
	task automatic clr(input logic [7:0] lo);
		rd(TCSI_OFS_STATUS);
		rd(lo);
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge i_clock);
		bad_count++;
		complete_run;
	end

	initial begin
		void'($urandom(32'h4B62));
		repeat (4) @(posedge i_clock);
		i_rst_n <= 1'h1;
		rd(TCSI_OFS_CTRL_A);
		chk("ctrl_a reset", 32'h0, rv);
		rd(TCSI_OFS_CTRL_B);
		chk("ctrl_b reset", 32'h0, rv);
		stf(TCSI_F_FREEZE, 1'h0);
		rd(8'h40);
		chk("unmapped resp", 32'(TCSI_RESP_SLVERR), 32'(rs));
		for (int i = 0; i < 4; i++) begin
			m = $urandom & 32'hFF;
			wr(i[0] ? TCSI_OFS_CTRL_B : TCSI_OFS_CTRL_A, 8'(m));
			rd(i[0] ? TCSI_OFS_CTRL_B : TCSI_OFS_CTRL_A);
			chk("ctrl readback", 32'(m), rv);
		end
		wr(TCSI_OFS_CTRL_A, 8'h00);
		wr(TCSI_OFS_CTRL_B, 8'hC0);
		wr(TCSI_OFS_STATUS, 8'h04);
		chk("oe frozen", 32'h0, {30'h0, oe1, oe2});
		wr(TCSI_OFS_STATUS, 8'h00);
		for (int lv = 0; lv < 2; lv++) begin
			wr(TCSI_OFS_CTRL_A, lv[0] ? 8'h1D : 8'h18);
			repeat (2) @(posedge i_clock);
			chk("pin1 forced", 32'(lv), 32'(p1));
			chk("pin2 forced", 32'(lv), 32'(p2));
			chk("oe pins", 32'h3, {30'h0, oe1, oe2});
		end
		// Overflow flag, its request and its two-step clear
		wr(TCSI_OFS_STATUS, 8'h04);
		clr(TCSI_OFS_CNT_LO);
		wr(TCSI_OFS_CNT_LO, 8'h00);
		rd(TCSI_OFS_CNT_HI);
		chk("count high", 32'hFF, rv);
		rd(TCSI_OFS_CNT_LO);
		chk("count low", 32'hFC, rv);
		stf(TCSI_F_OVF, 1'h0);
		wr(TCSI_OFS_CTRL_A, 8'h20);
		chk("irq idle", 32'h0, 32'(irq));
		wr(TCSI_OFS_STATUS, 8'h00);
		repeat (40) @(posedge i_clock);
		chk("irq ovf", 32'h1, 32'(irq));
		irq_mask <= 1'h1;
		wait_st <= 1'h1;
		repeat (2) @(posedge i_clock);
		chk("irq masked", 32'h0, 32'(irq));
		chk("wake", 32'h1, 32'(wake));
		irq_mask <= 1'h0;
		wait_st <= 1'h0;
		stf(TCSI_F_OVF, 1'h1);
		rd(TCSI_OFS_ACNT_LO);
		stf(TCSI_F_OVF, 1'h1);
		rd(TCSI_OFS_CNT_LO);
		stf(TCSI_F_OVF, 1'h0);
		wr(TCSI_OFS_CNT_LO, 8'h00);
		stf(TCSI_F_OVF, 1'h0);
		repeat (40) @(posedge i_clock);
		rd(TCSI_OFS_CNT_LO);
		stf(TCSI_F_OVF, 1'h1);
		// Prescaler divide ratios over a fixed run, then frozen
		for (int k = 0; k < 3; k++) begin
			wr(TCSI_OFS_STATUS, 8'h04);
			wr(TCSI_OFS_CTRL_B, k == 0 ? 8'h04 : (k == 1 ? 8'h00 : 8'h08));
			wr(TCSI_OFS_CNT_LO, 8'h00);
			wr(TCSI_OFS_STATUS, 8'h00);
			repeat (80) @(posedge i_clock);
			wr(TCSI_OFS_STATUS, 8'h04);
			rd(TCSI_OFS_CNT_LO);
			e = rv;
			d = int'(8'(rv[7:0] - 8'hFC));
			chk("ticks", 32'h1, 32'(d >= 83 / (2 << k) - 2 && d <= 83 / (2 << k) + 2));
			repeat (20) @(posedge i_clock);
			rd(TCSI_OFS_CNT_LO);
			chk("frozen count", e, rv);
		end
		// Compare 1 match with its pin disabled, then enabled
		wr(TCSI_OFS_CTRL_B, 8'h04);
		wr(TCSI_OFS_CTRL_A, 8'h40);
		wr(TCSI_OFS_CMP1_HI, 8'h00);
		wr(TCSI_OFS_CMP1_LO, 8'h10);
		wr(TCSI_OFS_CNT_LO, 8'h00);
		clr(TCSI_OFS_CMP1_LO);
		chk("irq before match", 32'h0, 32'(irq));
		wr(TCSI_OFS_STATUS, 8'h00);
		repeat (60) @(posedge i_clock);
		stf(TCSI_F_CMP1, 1'h1);
		chk("irq match", 32'h1, 32'(irq));
		chk("oe1 off", 32'h0, 32'(oe1));
		wr(TCSI_OFS_CTRL_B, 8'h84);
		chk("pin1 match", 32'h0, 32'(p1));
		chk("oe1 on", 32'h1, 32'(oe1));
		clr(TCSI_OFS_CMP1_LO);
		stf(TCSI_F_CMP1, 1'h0);
		// Pulse width mode: period end reloads the counter and sets cap1_flag
		wr(TCSI_OFS_STATUS, 8'h04);
		wr(TCSI_OFS_CMP2_HI, 8'h00);
		wr(TCSI_OFS_CMP2_LO, 8'h20);
		wr(TCSI_OFS_CNT_LO, 8'h00);
		wr(TCSI_OFS_CTRL_A, 8'h04);
		wr(TCSI_OFS_CTRL_B, 8'h94);
		wr(TCSI_OFS_STATUS, 8'h00);
		repeat (200) @(posedge i_clock);
		stf(TCSI_F_CAP1, 1'h1);
		rd(TCSI_OFS_CNT_LO);
		chk("pwm period", 32'h1, 32'(rv <= 32'h20 || rv >= 32'hFC));
		clr(TCSI_OFS_CAP1_LO);
		// External clock edge choice
		for (int x = 0; x < 2; x++) begin
			wr(TCSI_OFS_CTRL_B, 8'h0C | 8'(x));
			tcsi_pin_model_i.set_ext(1'h0);
			wr(TCSI_OFS_CNT_LO, 8'h00);
			tcsi_pin_model_i.set_ext(1'h1);
			rd(TCSI_OFS_CNT_LO);
			chk("ext rise", 32'hFC + 32'(x), rv);
			tcsi_pin_model_i.set_ext(1'h0);
			rd(TCSI_OFS_CNT_LO);
			chk("ext fall", 32'hFD, rv);
		end
		// Capture edges: inactive edge first, then the active one
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 2; s++) begin
				wr(TCSI_OFS_CTRL_A, 8'h80 | 8'(s << 1));
				wr(TCSI_OFS_CTRL_B, 8'h0C | 8'(s << 1));
				tcsi_pin_model_i.set_cap(p, s[0]);
				clr(p[0] ? TCSI_OFS_CAP2_LO : TCSI_OFS_CAP1_LO);
				tcsi_pin_model_i.set_cap(p, !s[0]);
				stf(p[0] ? TCSI_F_CAP2 : TCSI_F_CAP1, 1'h0);
				chk("irq no capture", 32'h0, 32'(irq));
				tcsi_pin_model_i.set_cap(p, s[0]);
				stf(p[0] ? TCSI_F_CAP2 : TCSI_F_CAP1, 1'h1);
				chk("irq capture", 32'h1, 32'(irq));
				clr(p[0] ? TCSI_OFS_CAP2_LO : TCSI_OFS_CAP1_LO);
			end
		end
		complete_run;
	end
endmodule
